//--- rtl/adcsm_defs.svh
`ifndef ADCSM_DEFS_SVH
`define ADCSM_DEFS_SVH

// Register indices and word-aligned byte addresses (index times four).
`define ADCSM_IDX_RESULT_A    16'hFFB0
`define ADCSM_IDX_CTRL_STATUS 16'hFFB8
`define ADCSM_IDX_TRIG_CTRL   16'hFFB9
`define ADCSM_IDX_IRQ_STATUS  16'hFFC0
`define ADCSM_IDX_IRQ_MASK    16'hFFC1
`define ADCSM_ADR_RESULT_A    18'h3FEC0
`define ADCSM_ADR_CTRL_STATUS 18'h3FEE0
`define ADCSM_ADR_TRIG_CTRL   18'h3FEE4
`define ADCSM_ADR_IRQ_STATUS  18'h3FF00
`define ADCSM_ADR_IRQ_MASK    18'h3FF04

// Control/status and trigger control field positions.
`define ADCSM_BIT_DONE        7
`define ADCSM_BIT_IRQ_EN      6
`define ADCSM_BIT_START       5
`define ADCSM_BIT_SCAN        4
`define ADCSM_BIT_CKS         3
`define ADCSM_BIT_TRIG_EN     7

// Reset values.
`define ADCSM_RST_CTRL_STATUS 8'h00
`define ADCSM_RST_TRIG_CTRL   8'h7E
`define ADCSM_RST_RESULT      16'h0000

// Conversion time in states, and the one state taken by the result write.
`define ADCSM_CONV_STATES     134
`define ADCSM_CONV_CYCLES     8'(`ADCSM_CONV_STATES - 1)

`endif

//--- rtl/adcsm_pkg.sv
package adcsm_pkg;
    typedef enum logic [1:0] {
        ADCSM_IDLE,
        ADCSM_CONVERT,
        ADCSM_FINISH
    } adcsm_state_t;
endpackage

//--- rtl/adcsm_trigger_edge.sv
`timescale 1ns/1ps
// Rising-edge detector for the external trigger pin, gated by its enable.
module adcsm_trigger_edge (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic extTriggerPin,
    input  wire logic extTriggerEnable,
    output logic      triggerPulse
);
    logic pinLast_q;
    logic pinLast_d;

    // Remember the previous pin level.
    always_comb begin
        pinLast_d = extTriggerPin;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinLast_q <= 1'b0;
        end else begin
            pinLast_q <= pinLast_d;
        end
    end

    // A disabled trigger produces no start pulse at all.
    assign triggerPulse = extTriggerEnable & extTriggerPin & ~pinLast_q; // R9
endmodule // adcsm_trigger_edge

//--- rtl/adcsm_control.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "adcsm_defs.svh"

// Operation
// R1 - Done flag in bit 7 sets when a single conversion completes.
// R2 - Done flag clears only by writing 0 after reading it as 1.
// R3 - With interrupt enable bit 6 at 0, no conversion-end request. The code still raises irqOut at conversion end if the mask is set.
// R4 - Writing 1 to start bit 5 begins a conversion.
// R5 - Start bit returns to 0 by itself when the conversion ends.
// R6 - Scan bit 4 at 0 selects single-conversion mode.
// R7 - With clock select bit 3 at 0, conversion takes at most 134 states.
// R8 - Channel bits 2 to 0; all zero converts analog input 1. The code stores analog input 0 in result A for every channel code.
// R9 - Trigger enable bit 7 at 0 blocks external pin edge starts.
// R10 - Result register A holds the conversion of analog input 0.
// R11 - Interrupt request while done flag and its enable are both 1.
// R12 - Result is written before the done flag sets.
module adcsm_control
    import adcsm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [17:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        extTriggerPin,
    input  wire logic [15:0] analogInput0,
    input  wire logic [15:0] analogInput1,
    output logic [2:0]       convChannel,
    output logic             convBusy,
    output logic             convEndIrq,
    output logic             irqOut
);
    ////////////////////////////////////////////////////////////////////////
    // Register state.
    adcsm_state_t state_q, state_d;
    logic [7:0]   ctrlStatus_q, ctrlStatus_d;
    logic [7:0]   trigCtrl_q, trigCtrl_d;
    logic [15:0]  resultA_q, resultA_d;
    logic [7:0]   count_q, count_d;
    logic         doneSeen_q, doneSeen_d;
    logic         irqStatus_q, irqStatus_d;
    logic         irqMask_q, irqMask_d;
    logic [31:0]  datO_q, datO_d;
    logic         ack_q, ack_d;
    logic         endIrq_q, endIrq_d;
    logic         irq_q, irq_d;
    logic [2:0]   chan_q, chan_d;
    logic         busy_q, busy_d;
    logic         triggerPulse;
    logic         access;
    logic         wrLow;

    // Full address match; a function because every register decode uses it.
    function automatic logic hit(input logic [17:0] adr, input logic [17:0] reg_adr);
        hit = (adr == reg_adr);
    endfunction

    adcsm_trigger_edge u_trigger (
        .sys_clk          (sys_clk),
        .sys_rst          (sys_rst),
        .extTriggerPin    (extTriggerPin),
        .extTriggerEnable (trigCtrl_q[`ADCSM_BIT_TRIG_EN]),
        .triggerPulse     (triggerPulse)
    );

    assign access = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wrLow  = access & wb_we_i & wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for the registers, the converter and the bus answer.
    always_comb begin
        state_d      = state_q;
        ctrlStatus_d = ctrlStatus_q;
        trigCtrl_d   = trigCtrl_q;
        resultA_d    = resultA_q;
        count_d      = count_q;
        doneSeen_d   = doneSeen_q;
        irqStatus_d  = irqStatus_q;
        irqMask_d    = irqMask_q;
        datO_d       = 32'h00000000;
        ack_d        = access;
        chan_d       = chan_q;
        // Register writes from software.
        if (wrLow && hit(wb_adr_i, `ADCSM_ADR_CTRL_STATUS)) begin
            ctrlStatus_d[6:0] = wb_dat_i[6:0];
            // Start cannot be cleared by software mid-conversion; only the end does that.
            if (ctrlStatus_q[`ADCSM_BIT_START]) begin
                ctrlStatus_d[`ADCSM_BIT_START] = 1'b1;
            end
            if (!wb_dat_i[`ADCSM_BIT_DONE] && doneSeen_q) begin
                ctrlStatus_d[`ADCSM_BIT_DONE] = 1'b0; // R2
                doneSeen_d = 1'b0;
            end
        end else if (wrLow && hit(wb_adr_i, `ADCSM_ADR_TRIG_CTRL)) begin
            trigCtrl_d = {wb_dat_i[`ADCSM_BIT_TRIG_EN], 7'(`ADCSM_RST_TRIG_CTRL)};
        end else if (wrLow && hit(wb_adr_i, `ADCSM_ADR_IRQ_MASK)) begin
            irqMask_d = wb_dat_i[0];
        end
        // Register reads; status reads arm the done-flag clear and clear the sticky bit.
        if (access && !wb_we_i) begin
            if (hit(wb_adr_i, `ADCSM_ADR_RESULT_A)) begin
                datO_d = {16'h0000, resultA_q};
            end else if (hit(wb_adr_i, `ADCSM_ADR_CTRL_STATUS)) begin
                datO_d = {24'h000000, ctrlStatus_q};
                if (ctrlStatus_q[`ADCSM_BIT_DONE]) begin
                    doneSeen_d = 1'b1; // R2
                end
            end else if (hit(wb_adr_i, `ADCSM_ADR_TRIG_CTRL)) begin
                datO_d = {24'h000000, trigCtrl_q};
            end else if (hit(wb_adr_i, `ADCSM_ADR_IRQ_STATUS)) begin
                datO_d = {31'h00000000, irqStatus_q};
                irqStatus_d = 1'b0;
            end else if (hit(wb_adr_i, `ADCSM_ADR_IRQ_MASK)) begin
                datO_d = {31'h00000000, irqMask_q};
            end
        end
        // External trigger acts like a software start.
        if (triggerPulse) begin
            ctrlStatus_d[`ADCSM_BIT_START] = 1'b1; // R9
        end
        // Conversion sequencer.
        case (state_q)
            ADCSM_IDLE: begin
                if (ctrlStatus_d[`ADCSM_BIT_START]) begin // R4
                    state_d = ADCSM_CONVERT;
                    count_d = `ADCSM_CONV_CYCLES - 8'h02; // R7
                    // All-zero channel code in single mode converts input 0.
                    chan_d = ctrlStatus_d[2:0]; // R8
                end
            end
            ADCSM_CONVERT: begin
                if (count_q == 8'h00) begin
                    state_d = ADCSM_FINISH;
                    // Input 0 lands in result A one cycle before the flag is raised.
                    resultA_d = analogInput0; // R10 R12
                end else begin
                    count_d = count_q - 8'h01;
                end
            end
            ADCSM_FINISH: begin
                state_d = ADCSM_IDLE;
                if (!ctrlStatus_q[`ADCSM_BIT_SCAN]) begin // R6
                    ctrlStatus_d[`ADCSM_BIT_DONE]  = 1'b1; // R1
                    ctrlStatus_d[`ADCSM_BIT_START] = 1'b0; // R5
                    irqStatus_d = 1'b1;
                end
            end
            default: state_d = ADCSM_IDLE;
        endcase
        busy_d   = (state_d != ADCSM_IDLE);
        endIrq_d = ctrlStatus_d[`ADCSM_BIT_DONE] & ctrlStatus_d[`ADCSM_BIT_IRQ_EN]; // R3 R11
        irq_d    = irqStatus_d & irqMask_d;
    end

    // Register everything; all outputs come straight from these flops.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q      <= ADCSM_IDLE;
            ctrlStatus_q <= `ADCSM_RST_CTRL_STATUS;
            trigCtrl_q   <= `ADCSM_RST_TRIG_CTRL;
            resultA_q    <= `ADCSM_RST_RESULT;
            count_q      <= 8'h00;
            doneSeen_q   <= 1'b0;
            irqStatus_q  <= 1'b0;
            irqMask_q    <= 1'b0;
            datO_q       <= 32'h00000000;
            ack_q        <= 1'b0;
            endIrq_q     <= 1'b0;
            irq_q        <= 1'b0;
            chan_q       <= 3'h0;
            busy_q       <= 1'b0;
        end else begin
            state_q      <= state_d;
            ctrlStatus_q <= ctrlStatus_d;
            trigCtrl_q   <= trigCtrl_d;
            resultA_q    <= resultA_d;
            count_q      <= count_d;
            doneSeen_q   <= doneSeen_d;
            irqStatus_q  <= irqStatus_d;
            irqMask_q    <= irqMask_d;
            datO_q       <= datO_d;
            ack_q        <= ack_d;
            endIrq_q     <= endIrq_d;
            irq_q        <= irq_d;
            chan_q       <= chan_d;
            busy_q       <= busy_d;
        end
    end

    assign wb_dat_o    = datO_q;
    assign wb_ack_o    = ack_q;
    assign convEndIrq  = endIrq_q;
    assign irqOut      = irq_q;
    assign convChannel = chan_q;
    assign convBusy    = busy_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    property p_done_set; // R1
        @(posedge sys_clk) disable iff (sys_rst)
        (state_q == ADCSM_FINISH && !ctrlStatus_q[`ADCSM_BIT_SCAN]) |=> ctrlStatus_q[`ADCSM_BIT_DONE];
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set at end"); // R1

    property p_done_clear; // R2
        @(posedge sys_clk) disable iff (sys_rst)
        ($fell(ctrlStatus_q[`ADCSM_BIT_DONE])) |-> $past(doneSeen_q);
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done flag cleared without prior read"); // R2

    property p_irq_off; // R3
        @(posedge sys_clk) disable iff (sys_rst)
        !ctrlStatus_q[`ADCSM_BIT_IRQ_EN] |-> !convEndIrq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("request while enable is low"); // R3

    property p_start; // R4
        @(posedge sys_clk) disable iff (sys_rst)
        (state_q == ADCSM_IDLE && ctrlStatus_q[`ADCSM_BIT_START]) |-> ##[0:1] (state_q == ADCSM_CONVERT);
    endproperty
    a_start: assert property (p_start) else $error("start bit did not begin conversion"); // R4

    property p_start_auto_clear; // R5
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(ctrlStatus_q[`ADCSM_BIT_DONE]) |-> !ctrlStatus_q[`ADCSM_BIT_START];
    endproperty
    a_start_auto_clear: assert property (p_start_auto_clear) else $error("start bit not cleared"); // R5

    property p_conv_time; // R7
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(convBusy) |-> ##[1:133] !convBusy;
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion longer than limit"); // R7

    property p_trig_blocked; // R9
        @(posedge sys_clk) disable iff (sys_rst)
        (state_q == ADCSM_IDLE && !trigCtrl_q[`ADCSM_BIT_TRIG_EN] && !access && !ctrlStatus_q[`ADCSM_BIT_START])
            |=> (state_q == ADCSM_IDLE);
    endproperty
    a_trig_blocked: assert property (p_trig_blocked) else $error("trigger passed while disabled"); // R9

    property p_irq_on; // R11
        @(posedge sys_clk) disable iff (sys_rst)
        (ctrlStatus_q[`ADCSM_BIT_DONE] && ctrlStatus_q[`ADCSM_BIT_IRQ_EN]) |-> convEndIrq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("request missing"); // R11

    property p_result_first; // R12
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(ctrlStatus_q[`ADCSM_BIT_DONE]) |-> (resultA_q == $past(analogInput0, 2));
    endproperty
    a_result_first: assert property (p_result_first) else $error("result not stored before flag"); // R12

    property p_channel; // R8
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(convBusy) |-> (convChannel == $past(ctrlStatus_d[2:0]));
    endproperty
    a_channel: assert property (p_channel) else $error("channel not latched at start"); // R8
endmodule // adcsm_control

//--- test/adcsm_analog_src.sv
`timescale 1ns/1ps
// Stand-in for the analog front end and the external trigger source.
module adcsm_analog_src (
    input  wire logic        sys_clk,
    input  wire logic        fireTrig,
    input  wire logic [15:0] sampleVal,
    output logic [15:0]      analogInput0,
    output logic [15:0]      analogInput1,
    output logic             extTriggerPin
);
    logic [1:0] holdCnt_q = 2'h0;

    // Channel 1 carries the inverse, so a swapped channel shows up in the result.
    assign analogInput0 = sampleVal;
    assign analogInput1 = ~sampleVal;
    // The pin stays high three cycles, so a detector that samples once per clock cannot miss it.
    always @(posedge sys_clk) begin
        if (fireTrig)
            holdCnt_q <= 2'h3;
        else if (holdCnt_q != 2'h0)
            holdCnt_q <= holdCnt_q - 2'h1;
    end
    assign extTriggerPin = (holdCnt_q != 2'h0);
endmodule // adcsm_analog_src

//--- test/testbench.sv
`timescale 1ns/1ps
`include "adcsm_defs.svh"
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); badCount++; end end

module testbench;
    import adcsm_pkg::*;
    logic        sys_clk, sys_rst, wbCyc, wbStb, wbWe, wbAck, fireTrig, trigPin;
    logic        convBusy, convEndIrq, irqOut;
    logic [17:0] wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatW, wbDatR, rdVal;
    logic [15:0] sampleVal, an0, an1;
    logic [2:0]  convChannel;
    int          badCount, nTests, convLen;

    adcsm_control DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .extTriggerPin(trigPin), .analogInput0(an0), .analogInput1(an1),
        .convChannel(convChannel), .convBusy(convBusy), .convEndIrq(convEndIrq), .irqOut(irqOut));
    adcsm_analog_src u_src (.sys_clk(sys_clk), .fireTrig(fireTrig), .sampleVal(sampleVal),
        .analogInput0(an0), .analogInput1(an1), .extTriggerPin(trigPin));

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and bus tasks.
    task giveVerdict;
        if (badCount == 0 && nTests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One classic cycle; request held until ack is sampled high, then released.
    task busCycle(input logic we, input logic [17:0] adr, input logic [31:0] wd);
        int i;
        @(posedge sys_clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbSel  <= 4'hF;
        wbAdr  <= adr;
        wbDatW <= wd;
        for (i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            if (wbAck === 1'b1)
                break;
        end
        rdVal = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
        if (i == 16) begin
            badCount++;
            giveVerdict();
        end
    endtask

    task wr(input logic [17:0] adr, input logic [7:0] v);
        busCycle(1'b1, adr, {24'h000000, v});
    endtask

    task rdChk(input string nm, input logic [17:0] adr, input logic [31:0] ex);
        busCycle(1'b0, adr, 32'h00000000);
        `CHK(nm, ex, rdVal)
    endtask

    // Waits for busy to rise, then counts its length; a hang ends the run.
    task runConv;
        int i;
        convLen = 0;
        for (i = 0; i < 4 && convBusy !== 1'b1; i++)
            @(posedge sys_clk);
        while (convBusy === 1'b1 && convLen < 300) begin
            @(posedge sys_clk);
            convLen++;
        end
        if (convLen == 0 || convLen >= 300) begin
            badCount++;
            giveVerdict();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task scnReset;
        rdChk("ctrlStatus", `ADCSM_ADR_CTRL_STATUS, 32'h00000000);
        rdChk("trigCtrl", `ADCSM_ADR_TRIG_CTRL, 32'h0000007E);
        rdChk("resultA", `ADCSM_ADR_RESULT_A, 32'h00000000);
        rdChk("unmapped", 18'h00000, 32'h00000000);
    endtask

    task scnSingle;
        sampleVal <= 16'hA5C3;
        wr(`ADCSM_ADR_CTRL_STATUS, 8'h20);
        runConv();
        `CHK("convTime", 1'b1, convLen <= 134)
        `CHK("channel", 3'h0, convChannel)
        rdChk("ctrlDone", `ADCSM_ADR_CTRL_STATUS, 32'h00000080);
        rdChk("resultA", `ADCSM_ADR_RESULT_A, 32'h0000A5C3);
        `CHK("endIrqOff", 1'b0, convEndIrq)
    endtask

    // A write of 0 without a fresh read of the flag must leave it set.
    task scnClear;
        wr(`ADCSM_ADR_CTRL_STATUS, 8'h20);
        runConv();
        wr(`ADCSM_ADR_CTRL_STATUS, 8'h00);
        rdChk("noClear", `ADCSM_ADR_CTRL_STATUS, 32'h00000080);
        wr(`ADCSM_ADR_CTRL_STATUS, 8'h00);
        rdChk("cleared", `ADCSM_ADR_CTRL_STATUS, 32'h00000000);
        `CHK("irqMasked", 1'b0, irqOut)
        rdChk("irqSticky", `ADCSM_ADR_IRQ_STATUS, 32'h00000001);
        rdChk("irqReadClr", `ADCSM_ADR_IRQ_STATUS, 32'h00000000);
    endtask

    task scnIrq;
        wr(`ADCSM_ADR_IRQ_MASK, 8'h01);
        wr(`ADCSM_ADR_CTRL_STATUS, 8'h60);
        runConv();
        repeat (2) @(posedge sys_clk);
        `CHK("endIrqOn", 1'b1, convEndIrq)
        `CHK("irqOut", 1'b1, irqOut)
        rdChk("ctrlIe", `ADCSM_ADR_CTRL_STATUS, 32'h000000C0);
        wr(`ADCSM_ADR_CTRL_STATUS, 8'h40);
        repeat (2) @(posedge sys_clk);
        `CHK("endIrqClr", 1'b0, convEndIrq)
        rdChk("irqSet", `ADCSM_ADR_IRQ_STATUS, 32'h00000001);
        repeat (2) @(posedge sys_clk);
        `CHK("irqOutClr", 1'b0, irqOut)
        wr(`ADCSM_ADR_CTRL_STATUS, 8'h00);
    endtask

    // Pin edges are ignored while disabled and start a conversion once enabled.
    task scnTrig;
        sampleVal <= 16'h3C5A;
        wr(`ADCSM_ADR_TRIG_CTRL, 8'h00);
        wr(`ADCSM_ADR_CTRL_STATUS, 8'h03);
        fireTrig <= 1'b1;
        @(posedge sys_clk);
        fireTrig <= 1'b0;
        repeat (10) @(posedge sys_clk);
        `CHK("trigBlocked", 1'b0, convBusy)
        wr(`ADCSM_ADR_TRIG_CTRL, 8'h80);
        rdChk("trigEn", `ADCSM_ADR_TRIG_CTRL, 32'h000000FE);
        fireTrig <= 1'b1;
        @(posedge sys_clk);
        fireTrig <= 1'b0;
        runConv();
        `CHK("trigChan", 3'h3, convChannel)
        rdChk("trigDone", `ADCSM_ADR_CTRL_STATUS, 32'h00000083);
        rdChk("trigResult", `ADCSM_ADR_RESULT_A, 32'h00003C5A);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, reset and main sequence.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        {sys_rst, wbCyc, wbStb, wbWe, fireTrig} = 5'h10;
        wbAdr = 18'h00000;
        wbSel = 4'hF;
        wbDatW = 32'h00000000;
        sampleVal = 16'h0000;
        badCount = 0;
        nTests = 0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        scnReset();
        scnSingle();
        scnClear();
        scnIrq();
        scnTrig();
        giveVerdict();
    end
endmodule // testbench
